// [uep_host.sv]
// host controller driving a 2048x8 uv eprom through its pins
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module uep_host #(
  parameter int unsigned PULSE_CYC = uep_pkg::PULSE_REC_CYC, // program pulse length
  parameter int unsigned PULSE_CAP = uep_pkg::PULSE_MAX_CYC  // hard cap on pulse
) (
  // clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          reset_i,
  // user request and answer
  input  wire logic                          req_valid_i,
  input  var  uep_pkg::uep_req_t             req_i,
  output logic                               req_ready_o,
  output logic                               rsp_valid_o,
  output var  uep_pkg::uep_rsp_t             rsp_o,
  // device pins
  output logic [uep_pkg::ADDR_W-1:0]         addr_o,
  output logic                               enable_n_o,
  output logic                               oe_n_o,
  output logic                               vpp_high_o,
  input  wire logic [uep_pkg::DATA_W-1:0]    dq_i,
  output logic [uep_pkg::DATA_W-1:0]         dq_o,
  output logic                               dq_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  uep_pkg::uep_state_t                state_reg, state_next;
  logic [uep_pkg::CNT_W-1:0]          cnt_reg, cnt_next;      // phase timer
  logic [uep_pkg::ADDR_W-1:0]         addr_reg, addr_next;
  logic [uep_pkg::DATA_W-1:0]         wdata_reg, wdata_next;  // word to program
  logic                               en_n_reg, en_n_next;
  logic                               oe_n_reg, oe_n_next;
  logic                               vpp_reg, vpp_next;
  logic                               dqoe_reg, dqoe_next;
  logic                               rdy_reg, rdy_next;
  logic                               rv_reg, rv_next;
  uep_pkg::uep_rsp_t                  rsp_reg, rsp_next;
  logic [uep_pkg::DATA_W-1:0]         dq_s1_reg, dq_s2_reg;   // pin synchroniser

  localparam logic [uep_pkg::CNT_W-1:0] SETUP_C  = uep_pkg::CNT_W'(uep_pkg::SETUP_CYC);
  localparam logic [uep_pkg::CNT_W-1:0] ACCESS_C = uep_pkg::CNT_W'(uep_pkg::ACCESS_CYC);
  localparam logic [uep_pkg::CNT_W-1:0] VPP_C    = uep_pkg::CNT_W'(uep_pkg::VPP_CYC);
  // the shorter of the chosen width and the cap keeps the pulse legal
  localparam logic [uep_pkg::CNT_W-1:0] PULSE_C  =
    uep_pkg::CNT_W'((PULSE_CYC < PULSE_CAP) ? PULSE_CYC : PULSE_CAP);

  // verify: every zero asked for must read zero; ones are don't care
  function automatic logic zeros_ok(input logic [uep_pkg::DATA_W-1:0] want,
                                    input logic [uep_pkg::DATA_W-1:0] got);
    zeros_ok = ((~want) & got) == '0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    en_n_next  = en_n_reg;
    oe_n_next  = oe_n_reg;
    vpp_next   = vpp_reg;
    dqoe_next  = dqoe_reg;
    rdy_next   = 1'b0;
    rv_next    = 1'b0;
    rsp_next   = rsp_reg;
    unique case (state_reg)
      uep_pkg::UEP_IDLE:
      begin
        // standby between requests: enable high floats the device outputs
        en_n_next = 1'b1;
        rdy_next  = 1'b1;
        if (req_valid_i && rdy_reg)
        begin
          rdy_next   = 1'b0;
          addr_next  = req_i.addr;
          wdata_next = req_i.data;
          cnt_next   = '0;
          unique case (req_i.cmd)
            uep_pkg::UEP_CMD_READ:
            begin
              // address and enable move together, access counted from both
              en_n_next  = 1'b0;
              oe_n_next  = 1'b0;
              state_next = uep_pkg::UEP_RD_WAIT;
            end
            uep_pkg::UEP_CMD_PROG, uep_pkg::UEP_CMD_VERIFY:
            begin
              // verify shares the program path: one pulse, then read back
              vpp_next   = 1'b1;
              oe_n_next  = 1'b1;
              en_n_next  = 1'b0;
              state_next = uep_pkg::UEP_PG_VPP;
            end
            // the spare code is dropped, the device stays in standby
            default: state_next = uep_pkg::UEP_IDLE;
          endcase
        end
      end
      uep_pkg::UEP_RD_WAIT, uep_pkg::UEP_VF_WAIT:
      begin
        cnt_next = cnt_reg + 1'b1;
        // two synchroniser stages are added on top of the access delay
        if (cnt_reg == ACCESS_C + 2)
        begin
          rsp_next.data = dq_s2_reg;
          rsp_next.ok   = (state_reg == uep_pkg::UEP_RD_WAIT) ||
                          zeros_ok(wdata_reg, dq_s2_reg);
          rv_next       = 1'b1;
          oe_n_next     = 1'b1;
          // after verify enable stays low: a rise under high supply would strobe
          en_n_next     = (state_reg == uep_pkg::UEP_RD_WAIT);
          cnt_next      = '0;
          state_next    = (state_reg == uep_pkg::UEP_RD_WAIT) ? uep_pkg::UEP_IDLE
                                                               : uep_pkg::UEP_VPP_OFF;
        end
      end
      uep_pkg::UEP_PG_VPP:
      begin
        cnt_next = cnt_reg + 1'b1;
        // supply settled: drive the word, the device sits in inhibit meanwhile
        if (cnt_reg == VPP_C)
        begin
          cnt_next   = '0;
          dqoe_next  = 1'b1;
          state_next = uep_pkg::UEP_PG_SETUP;
        end
      end
      uep_pkg::UEP_PG_SETUP:
      begin
        cnt_next = cnt_reg + 1'b1;
        // address, data and oe-high must be settled before the rising edge
        if (cnt_reg == SETUP_C)
        begin
          cnt_next   = '0;
          en_n_next  = 1'b1;
          state_next = uep_pkg::UEP_PG_PULSE;
        end
      end
      uep_pkg::UEP_PG_PULSE:
      begin
        cnt_next = cnt_reg + 1'b1;
        // one bounded pulse, never left high as a level
        if (cnt_reg == PULSE_C - 1'b1)
        begin
          cnt_next   = '0;
          en_n_next  = 1'b0;
          state_next = uep_pkg::UEP_PG_HOLD;
        end
      end
      uep_pkg::UEP_PG_HOLD:
      begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == SETUP_C)
        begin
          // release data, then verify with vpp still high
          cnt_next   = '0;
          dqoe_next  = 1'b0;
          oe_n_next  = 1'b0;
          state_next = uep_pkg::UEP_VF_WAIT;
        end
      end
      uep_pkg::UEP_VPP_OFF:
      begin
        // enable held low until idle, so the supply falls in inhibit
        cnt_next = cnt_reg + 1'b1;
        vpp_next = 1'b0;
        if (cnt_reg == VPP_C)
        begin
          cnt_next   = '0;
          state_next = uep_pkg::UEP_IDLE;
        end
      end
      default: state_next = uep_pkg::UEP_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg <= uep_pkg::UEP_IDLE;
      cnt_reg   <= '0;
      addr_reg  <= '0;
      wdata_reg <= uep_pkg::BLANK_WORD;
      en_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      vpp_reg   <= 1'b0;
      dqoe_reg  <= 1'b0;
      rdy_reg   <= 1'b0;
      rv_reg    <= 1'b0;
      rsp_reg   <= '0;
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      en_n_reg  <= en_n_next;
      oe_n_reg  <= oe_n_next;
      vpp_reg   <= vpp_next;
      dqoe_reg  <= dqoe_next;
      rdy_reg   <= rdy_next;
      rv_reg    <= rv_next;
      rsp_reg   <= rsp_next;
      dq_s1_reg <= dq_i;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // outputs straight from flip-flops
  assign addr_o      = addr_reg;
  assign enable_n_o  = en_n_reg;
  assign oe_n_o      = oe_n_reg;
  assign vpp_high_o  = vpp_reg;
  assign dq_o        = wdata_reg;
  assign dq_oe_o     = dqoe_reg;
  assign req_ready_o = rdy_reg;
  assign rsp_valid_o = rv_reg;
  assign rsp_o       = rsp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // strobe high under high supply only inside one bounded pulse
  property p_pulse_bounded;
    @(posedge mclk_i) disable iff (reset_i)
    (vpp_reg && en_n_reg) |-> (state_reg == uep_pkg::UEP_PG_PULSE) && (cnt_reg < PULSE_C);
  endproperty
  a_pulse_bounded: assert property (p_pulse_bounded) else $error("strobe outside pulse");
  property p_prog_pins;
    @(posedge mclk_i) disable iff (reset_i)
    (state_reg == uep_pkg::UEP_PG_PULSE) |-> (vpp_reg && oe_n_reg && dqoe_reg);
  endproperty
  a_prog_pins: assert property (p_prog_pins) else $error("bad pins in pulse");
  property p_no_drive_on_read;
    @(posedge mclk_i) disable iff (reset_i)
    (!oe_n_reg) |-> !dqoe_reg;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus fight");
  property p_pulse_falls;
    @(posedge mclk_i) disable iff (reset_i)
    (state_reg == uep_pkg::UEP_PG_PULSE && cnt_reg == PULSE_C - 1'b1) |=> !en_n_reg;
  endproperty
  a_pulse_falls: assert property (p_pulse_falls) else $error("enable stuck high");
  property p_idle_standby;
    @(posedge mclk_i) disable iff (reset_i)
    (state_reg == uep_pkg::UEP_IDLE && state_next == uep_pkg::UEP_IDLE) |=> en_n_reg;
  endproperty
  a_idle_standby: assert property (p_idle_standby) else $error("no standby");
  property p_read_wait;
    @(posedge mclk_i) disable iff (reset_i)
    (state_reg == uep_pkg::UEP_IDLE && state_next == uep_pkg::UEP_RD_WAIT) |=> !rv_reg [*8];
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read answered early");
  property p_vpp_verify;
    @(posedge mclk_i) disable iff (reset_i)
    (state_reg == uep_pkg::UEP_VF_WAIT) |-> vpp_reg && !en_n_reg && !oe_n_reg && !dqoe_reg;
  endproperty
  a_vpp_verify: assert property (p_vpp_verify) else $error("verify without vpp");
  property p_addr_stable;
    @(posedge mclk_i) disable iff (reset_i)
    (state_reg == uep_pkg::UEP_PG_PULSE) |=> $stable(addr_reg);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved");
endmodule

`default_nettype wire

// [uep_pkg.sv]
// package: timing constants, commands and states of the eprom host controller
`default_nettype none
package uep_pkg;
  localparam int unsigned CLK_HZ        = 25000000;  // mclk_i rate
  localparam int unsigned ADDR_W        = 11;        // 2048 words
  localparam int unsigned DATA_W        = 8;
  // times in their own units, as printed
  localparam int unsigned PULSE_MIN_MS  = 1;         // least pulse width
  localparam int unsigned PULSE_REC_MS  = 2;         // recommended pulse width
  localparam int unsigned PULSE_MAX_MS  = 55;        // longest pulse width
  localparam int unsigned PULSE_LONG_MS = 45;        // below this, extra pulses apply
  localparam int unsigned SETUP_US      = 2;         // address/data/oe setup and hold
  localparam int unsigned ACCESS_NS     = 450;       // enable_to_data_delay, slowest grade
  localparam int unsigned VPP_SETTLE_US = 2;         // supply switch settle
  // cycle counts derived from the clock rate
  localparam int unsigned PULSE_REC_CYC = PULSE_REC_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned SETUP_CYC     = (SETUP_US * (CLK_HZ / 1000000)) + 1;
  localparam int unsigned ACCESS_CYC    = (ACCESS_NS * (CLK_HZ / 1000000) + 999) / 1000 + 1;
  localparam int unsigned VPP_CYC       = VPP_SETTLE_US * (CLK_HZ / 1000000);
  localparam int unsigned CNT_W         = 24;
  localparam logic [DATA_W-1:0] BLANK_WORD = 8'hFF;  // erased word

  typedef enum logic [1:0] {UEP_CMD_READ, UEP_CMD_PROG, UEP_CMD_VERIFY} uep_cmd_t;

  typedef struct packed {
    uep_cmd_t            cmd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } uep_req_t;

  typedef struct packed {
    logic                ok;     // verify matched the intended zeros
    logic [DATA_W-1:0]   data;   // word read from the device
  } uep_rsp_t;

  typedef enum logic [3:0] {
    UEP_IDLE, UEP_RD_WAIT, UEP_PG_VPP, UEP_PG_SETUP, UEP_PG_PULSE,
    UEP_PG_HOLD, UEP_VF_WAIT, UEP_VPP_OFF
  } uep_state_t;
endpackage
`default_nettype wire

// [uep_dev_model.sv]
// behavioural model of the 2048x8 uv eprom as seen at its pins
`timescale 1ns/1ps
`default_nettype none
module uep_dev_model #(
  parameter int unsigned ACC_NS = 450  // enable or address to data valid
) (
  // device pins
  input  wire logic [10:0] addr_i,
  input  wire logic        enable_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        vpp_high_i,
  input  wire logic [7:0]  dq_host_i,
  input  wire logic        dq_host_oe_i,
  // resolved data wire and contention flag
  output logic [7:0]       dq_o,
  output logic             clash_o
);
  logic [7:0]  mem [2048];  // 2048 words of 8 bits
  logic [7:0]  junk;        // floating wire must not keep the last value
  wire  [10:0] addr_dly;    // inertial copies settle only when stable
  wire         en_dly;
  wire         drive;
  assign #(ACC_NS) addr_dly = addr_i;
  assign #(ACC_NS) en_dly = enable_n_i;
  // outputs on only with enable and oe low, read or verify
  assign drive = !enable_n_i && !oe_n_i;
  initial
  begin
    for (int i = 0; i < 2048; i++)
      mem[i] = 8'hFF;
    junk = 8'hA5;
    clash_o = 1'b0;
  end
  // released wire changes every cycle
  always #40 junk = {junk[6:0], ~junk[7]};
  // rising strobe with high supply and oe high clears zeros only
  always @(posedge enable_n_i)
    if (vpp_high_i && oe_n_i)
      mem[addr_i] = mem[addr_i] & dq_host_i;
  // data valid only once enable and address held for the access time
  always @*
  begin
    if (dq_host_oe_i)
      dq_o = dq_host_i;
    else if (drive && !en_dly && addr_dly == addr_i)
      dq_o = mem[addr_i];
    else
      dq_o = junk;
  end
  // contention judged 1 ns after a change, so a same-edge handover is no fight
  always @(dq_host_oe_i or drive)
    #1 if (dq_host_oe_i && drive)
      clash_o = 1'b1;
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the eprom host controller and its device model
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned PULSE = 20;  // shortened program pulse
  logic               mclk_i;
  logic               reset_i;
  logic               req_valid_i;
  uep_pkg::uep_req_t  req_i;
  uep_pkg::uep_rsp_t  rsp_o;
  logic               req_ready_o;
  logic               rsp_valid_o;
  logic               enable_n_o;
  logic               oe_n_o;
  logic               vpp_high_o;
  logic               dq_oe_o;
  logic               clash;
  logic [10:0]        addr_o;
  logic [7:0]         dq_o;
  logic [7:0]         dq_wire;
  int                 miscompares;
  int                 total_checks;
  int                 cycles;
  int                 hi_cnt;
  int                 hi_last;

  uep_host #(.PULSE_CYC(PULSE)) dut_u (
    .mclk_i(mclk_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
    .addr_o(addr_o), .enable_n_o(enable_n_o), .oe_n_o(oe_n_o),
    .vpp_high_o(vpp_high_o), .dq_i(dq_wire), .dq_o(dq_o), .dq_oe_o(dq_oe_o));

  uep_dev_model dev_u (
    .addr_i(addr_o), .enable_n_i(enable_n_o), .oe_n_i(oe_n_o),
    .vpp_high_i(vpp_high_o), .dq_host_i(dq_o), .dq_host_oe_i(dq_oe_o),
    .dq_o(dq_wire), .clash_o(clash));

  ////////////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // strobe width under high supply, and hang guard; sampled off the edge
  always @(negedge mclk_i)
  begin
    cycles++;
    if (enable_n_o === 1'b1 && vpp_high_o === 1'b1)
      hi_cnt++;
    else if (hi_cnt != 0)
    begin
      hi_last = hi_cnt;
      hi_cnt = 0;
    end
    if (cycles >= 20000)
    begin
      miscompares++;
      $display("[ERR] %0t run too long", $time);
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk_word(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // one request, sent once ready and held for one cycle, then wait for the answer
  task automatic do_req(input uep_pkg::uep_cmd_t cmd, input logic [10:0] a,
                        input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 1000)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    req_i <= '{cmd, a, d};
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 1000)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk_bit(rsp_valid_o, 1'b1);
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_blank();
    do_req(uep_pkg::UEP_CMD_READ, 11'h000, 8'h00);
    chk_word(rsp_o.data, 8'hFF);
    do_req(uep_pkg::UEP_CMD_READ, 11'h7FF, 8'h00);
    chk_word(rsp_o.data, 8'hFF);
    chk_bit(enable_n_o, 1'b1);
    chk_bit(oe_n_o, 1'b1);
    chk_bit(vpp_high_o, 1'b0);
    chk_word(addr_o[10:3], 8'hFF);
    $display("test blank done");
  endtask

  task automatic t_prog();
    do_req(uep_pkg::UEP_CMD_PROG, 11'h003, 8'h5A);
    chk_bit(rsp_o.ok, 1'b1);
    chk_word(8'(hi_last), 8'(PULSE));
    chk_bit(vpp_high_o, 1'b1);
    chk_bit(dq_oe_o, 1'b0);
    chk_bit(enable_n_o, 1'b0);
    do_req(uep_pkg::UEP_CMD_READ, 11'h003, 8'h00);
    chk_word(rsp_o.data, 8'h5A);
    $display("test program done");
  endtask

  task automatic t_zero_only();
    do_req(uep_pkg::UEP_CMD_PROG, 11'h003, 8'hF0);
    chk_bit(rsp_o.ok, 1'b1);
    chk_word(rsp_o.data, 8'h50);
    do_req(uep_pkg::UEP_CMD_READ, 11'h003, 8'h00);
    chk_word(rsp_o.data, 8'h50);
    do_req(uep_pkg::UEP_CMD_READ, 11'h004, 8'h00);
    chk_word(rsp_o.data, 8'hFF);
    $display("test zero only done");
  endtask

  task automatic t_verify();
    do_req(uep_pkg::UEP_CMD_VERIFY, 11'h7FF, 8'h00);
    chk_bit(rsp_o.ok, 1'b1);
    chk_word(rsp_o.data, 8'h00);
    do_req(uep_pkg::UEP_CMD_READ, 11'h7FF, 8'h00);
    chk_word(rsp_o.data, 8'h00);
    chk_bit(clash, 1'b0);
    $display("test verify done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    hi_cnt = 0;
    hi_last = 0;
    reset_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_blank();
    t_prog();
    t_zero_only();
    t_verify();
    end_of_test();
  end
endmodule
`default_nettype wire
